// ---- hdl/isl_pkg.sv ----
// constants and types shared by the interrupt source status latch
`default_nettype none
package isl_pkg;

  localparam int unsigned ISL_DATA_W = 32;
  localparam int unsigned ISL_ADDR_W = 16;
  localparam int unsigned ISL_EVT_W  = 3;

  // register byte addresses
  localparam logic [15:0] ISL_OFF_FLAGS    = 16'h9004;
  localparam logic [15:0] ISL_OFF_CTRL     = 16'h9040;
  localparam logic [15:0] ISL_OFF_IRQ_STAT = 16'h9044;
  localparam logic [15:0] ISL_OFF_IRQ_CLR  = 16'h9048;
  localparam logic [15:0] ISL_OFF_IRQ_EN   = 16'h904C;

  // field positions
  localparam int unsigned ISL_CTRL_CAPTURE_BIT = 0;
  localparam int unsigned ISL_EVT_NEW_BIT      = 0;
  localparam int unsigned ISL_EVT_LOST_BIT     = 1;
  localparam int unsigned ISL_EVT_BUSERR_BIT   = 2;

  // reset values
  localparam logic [31:0] ISL_RST_FLAGS  = 32'h0000_0000;
  localparam logic [0:0]  ISL_RST_CTRL   = 1'h1;
  localparam logic [2:0]  ISL_RST_IRQ    = 3'h0;
  localparam logic [31:0] ISL_RD_ZERO    = 32'h0000_0000;

  typedef struct packed {
    logic [ISL_ADDR_W-1:0] addr;
    logic                  write;
    logic [ISL_DATA_W-1:0] wdata;
  } isl_apb_req_s;

  typedef enum logic [1:0] {
    ISL_BUS_IDLE   = 2'b00,
    ISL_BUS_ACCESS = 2'b01,
    ISL_BUS_DONE   = 2'b10
  } isl_bus_state_e;

endpackage
`default_nettype wire

// ---- hdl/isl_flag_latch.sv ----
// sticky per-source flag latch with clear-over-set priority
`default_nettype none
module isl_flag_latch (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        hot_reset,
  input  wire logic [31:0] set_vec,
  input  wire logic [31:0] clr_vec,
  output var  logic [31:0] flags_q,
  output var  logic        new_flag_q,
  output var  logic        lost_set_q
);

  logic [31:0] flags_d;
  logic [31:0] rising;
  logic [31:0] collide;

  // clear wins over a same-cycle set
  assign flags_d = (flags_q | set_vec) & ~clr_vec;
  assign rising  = set_vec & ~flags_q & ~clr_vec;
  assign collide = set_vec & clr_vec;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_q    <= isl_pkg::ISL_RST_FLAGS;
      new_flag_q <= 1'b0;
      lost_set_q <= 1'b0;
    end else if (hot_reset) begin
      flags_q    <= isl_pkg::ISL_RST_FLAGS;
      new_flag_q <= 1'b0;
      lost_set_q <= 1'b0;
    end else begin
      flags_q    <= flags_d;
      new_flag_q <= |rising;
      lost_set_q <= |collide;
    end
  end

endmodule
`default_nettype wire

// ---- hdl/isl_top.sv ----
// interrupt source status latch with apb register slave
//
// The APB slave port was chosen for this implementation.
`default_nettype none
module isl_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        hot_reset,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic [31:0] src_event,
  output var  logic [31:0] src_flags,
  output var  logic        irq
);

  // ****************************************
  // bus request decode
  // ****************************************
  isl_pkg::isl_apb_req_s req;
  isl_pkg::isl_bus_state_e bus_q;
  isl_pkg::isl_bus_state_e bus_d;

  logic        pready_q;
  logic        pslverr_q;
  logic [31:0] prdata_q;
  logic [31:0] rdata_sel;

  logic        sel_flags;
  logic        sel_ctrl;
  logic        sel_irq_stat;
  logic        sel_irq_clr;
  logic        sel_irq_en;
  logic        hit;
  logic        addr_ok;
  logic        complete;
  logic        wr_fire;
  logic        rd_err;
  logic        bus_err;
  logic [31:0] strb_mask;

  function automatic logic [31:0] lane_mask(input logic [3:0] strb);
    lane_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
  endfunction

  function automatic logic addr_is(input logic [15:0] a, input logic [15:0] off);
    addr_is = (a == off);
  endfunction

  assign req.addr  = paddr[15:0];
  assign req.write = pwrite;
  assign req.wdata = pwdata;

  assign addr_ok      = (paddr[31:16] == 16'h0000);
  assign sel_flags    = addr_ok & addr_is(req.addr, isl_pkg::ISL_OFF_FLAGS);
  assign sel_ctrl     = addr_ok & addr_is(req.addr, isl_pkg::ISL_OFF_CTRL);
  assign sel_irq_stat = addr_ok & addr_is(req.addr, isl_pkg::ISL_OFF_IRQ_STAT);
  assign sel_irq_clr  = addr_ok & addr_is(req.addr, isl_pkg::ISL_OFF_IRQ_CLR);
  assign sel_irq_en   = addr_ok & addr_is(req.addr, isl_pkg::ISL_OFF_IRQ_EN);
  assign hit          = sel_flags | sel_ctrl | sel_irq_stat | sel_irq_clr | sel_irq_en;

  // writes to read-only status and reads of the write-only clear are errors
  assign rd_err   = (!req.write & sel_irq_clr) | (req.write & sel_irq_stat);
  assign bus_err  = !hit | rd_err;
  assign complete = psel & penable & (bus_q == isl_pkg::ISL_BUS_DONE);
  assign wr_fire  = complete & req.write & !bus_err;
  assign strb_mask = lane_mask(pstrb);

  // ****************************************
  // apb handshake: two wait states, all answers registered
  // ****************************************
  always_comb begin
    bus_d = bus_q;
    unique case (bus_q)
      isl_pkg::ISL_BUS_IDLE: begin
        if (psel && penable) begin
          bus_d = isl_pkg::ISL_BUS_ACCESS;
        end
      end
      isl_pkg::ISL_BUS_ACCESS: begin
        bus_d = isl_pkg::ISL_BUS_DONE;
      end
      isl_pkg::ISL_BUS_DONE: begin
        bus_d = isl_pkg::ISL_BUS_IDLE;
      end
      default: begin
        bus_d = isl_pkg::ISL_BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_q <= isl_pkg::ISL_BUS_IDLE;
    end else begin
      bus_q <= bus_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= isl_pkg::ISL_RD_ZERO;
    end else begin
      pready_q  <= (bus_d == isl_pkg::ISL_BUS_DONE);
      pslverr_q <= (bus_d == isl_pkg::ISL_BUS_DONE) & bus_err;
      prdata_q  <= ((bus_d == isl_pkg::ISL_BUS_DONE) & !req.write & !bus_err) ?
                   rdata_sel : isl_pkg::ISL_RD_ZERO;
    end
  end

  assign pready  = pready_q;
  assign pslverr = pslverr_q;
  assign prdata  = prdata_q;

  // ****************************************
  // control and interrupt registers
  // ****************************************
  logic                         capture_en_q;
  logic [isl_pkg::ISL_EVT_W-1:0] irq_stat_q;
  logic [isl_pkg::ISL_EVT_W-1:0] irq_stat_d;
  logic [isl_pkg::ISL_EVT_W-1:0] irq_en_q;
  logic [isl_pkg::ISL_EVT_W-1:0] irq_evt;
  logic [isl_pkg::ISL_EVT_W-1:0] irq_clr;
  logic                         irq_q;
  logic                         new_flag;
  logic                         lost_set;
  logic                         bus_err_evt;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture_en_q <= isl_pkg::ISL_RST_CTRL[0];
    end else if (wr_fire && sel_ctrl && pstrb[0]) begin
      capture_en_q <= req.wdata[isl_pkg::ISL_CTRL_CAPTURE_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_en_q <= isl_pkg::ISL_RST_IRQ;
    end else if (wr_fire && sel_irq_en && pstrb[0]) begin
      irq_en_q <= req.wdata[isl_pkg::ISL_EVT_W-1:0];
    end
  end

  assign bus_err_evt = complete & bus_err;
  assign irq_evt     = {bus_err_evt, lost_set, new_flag};
  assign irq_clr     = (wr_fire && sel_irq_clr && pstrb[0]) ?
                       req.wdata[isl_pkg::ISL_EVT_W-1:0] : isl_pkg::ISL_RST_IRQ;
  // a block event arriving with its clear is kept
  assign irq_stat_d  = (irq_stat_q & ~irq_clr) | irq_evt;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_q <= isl_pkg::ISL_RST_IRQ;
      irq_q      <= 1'b0;
    end else begin
      irq_stat_q <= irq_stat_d;
      irq_q      <= |(irq_stat_d & irq_en_q);
    end
  end

  assign irq = irq_q;

  // ****************************************
  // source flag latch
  // ****************************************
  logic [31:0] flags;
  logic [31:0] set_vec;
  logic [31:0] clr_vec;

  assign set_vec = capture_en_q ? src_event : isl_pkg::ISL_RST_FLAGS;
  // only an explicit write of ones or a hot reset clears; a read never touches the flags
  assign clr_vec = (wr_fire && sel_flags) ?
                   (req.wdata & strb_mask) : isl_pkg::ISL_RST_FLAGS;

  isl_flag_latch u_latch (
    .pclk       (pclk),
    .presetn    (presetn),
    .hot_reset  (hot_reset),
    .set_vec    (set_vec),
    .clr_vec    (clr_vec),
    .flags_q    (flags),
    .new_flag_q (new_flag),
    .lost_set_q (lost_set)
  );

  assign src_flags = flags;

  // ****************************************
  // read data selection
  // ****************************************
  logic [31:0] ctrl_word;
  logic [31:0] stat_word;
  logic [31:0] en_word;

  assign ctrl_word = {31'h0000_0000, capture_en_q};
  assign stat_word = {29'h0000_0000, irq_stat_q};
  assign en_word   = {29'h0000_0000, irq_en_q};

  assign rdata_sel = sel_flags    ? flags     :
                     sel_ctrl     ? ctrl_word :
                     sel_irq_stat ? stat_word :
                     sel_irq_en   ? en_word   : isl_pkg::ISL_RD_ZERO;

endmodule
`default_nettype wire

// ---- tb/isl_monitor.sv ----
// assertion checker for the status latch
`default_nettype none
module isl_monitor (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        hot_reset,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic        pready,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] src_event,
  input wire logic [31:0] src_flags
);
  // ***********
  // properties
  // ***********
  wire [31:0] lane = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
  wire        hit  = psel && penable && pready && pwrite;
  wire        at_f = paddr == {16'h0000, isl_pkg::ISL_OFF_FLAGS};
  wire [31:0] clr  = (hit && at_f) ? (pwdata & lane) : 32'h0000_0000;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_clr_wr;
    psel && !penable && pwrite ##1 penable && !pready [*2] ##1 penable && pready && |clr;
  endsequence
  AST_EVENT_SETS: assert property (
    !hot_reset |=> ($past(src_event) & ~$past(clr) & ~src_flags) == 0)
    else $error("event did not set its flag");
  AST_STICKY: assert property (
    !hot_reset |=> ($past(src_flags) & ~$past(clr) & ~src_flags) == 0)
    else $error("flag dropped without a clear");
  AST_NO_SPURIOUS: assert property (
    1 |=> (src_flags & ~$past(src_flags) & ~$past(src_event)) == 0)
    else $error("flag set without an event");
  AST_CLR_WINS: assert property (s_clr_wr |=> (src_flags & $past(clr)) == 0)
    else $error("cleared flag still set");
  AST_READ_KEEPS: assert property (psel && penable && pready && !pwrite && !hot_reset
    |=> ($past(src_flags) & ~src_flags) == 0)
    else $error("read cleared a flag");
  AST_OFFSET: assert property (
    hit && !at_f && !hot_reset |=> ($past(src_flags) & ~src_flags) == 0)
    else $error("write elsewhere cleared a flag");
  AST_HOT_CLEAR: assert property (hot_reset |=> src_flags == 32'h0000_0000)
    else $error("hot reset left flags set");
endmodule
bind isl_top isl_monitor i_mon (.pclk(pclk), .presetn(presetn), .hot_reset(hot_reset),
  .psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready), .paddr(paddr),
  .pwdata(pwdata), .pstrb(pstrb), .src_event(src_event), .src_flags(src_flags));
`default_nettype wire

// ---- tb/testbench.sv ----
// self-checking bench for the status latch
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk = 0, presetn = 0, hot_reset = 0, psel = 0, penable = 0, pwrite = 0, e;
  logic [31:0] paddr = '0, pwdata = '0, src_event = '0, m = '0, r;
  logic [3:0]  pstrb = 4'hf;
  wire  [31:0] prdata, src_flags;
  wire         pready, pslverr, irq;
  int          err_total = 0, n_checks = 0, seed = 33490;
  always #5 pclk = ~pclk;
  isl_top i_dut (.pclk(pclk), .presetn(presetn), .hot_reset(hot_reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .src_event(src_event),
    .src_flags(src_flags), .irq(irq));
  // *****************
  // tasks and model
  // *****************
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    n_checks++;
    if (s !== x) begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, x);
    end
  endtask
  task automatic print_verdict;
    if (err_total == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= {16'h0000, a};
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  always @(posedge pclk) begin
    if (!presetn || hot_reset) m = '0;
    else if (psel && penable && pready && pwrite && paddr == 32'h0000_9004) m = (m | src_event) & ~pwdata;
    else m = m | src_event;
  end
  always @(negedge pclk) if (presetn) chk(src_flags, m);
  initial begin
    #20us;
    err_total++;
    print_verdict;
  end
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 40; i++) begin
      src_event <= $random(seed) & $random(seed);
      apb(1'b1, isl_pkg::ISL_OFF_FLAGS, $random(seed));
      chk({31'h0000_0000, e}, '0);
      src_event <= '0;
      apb(1'b0, isl_pkg::ISL_OFF_FLAGS, '0);
      chk(r, m);
      chk({31'h0000_0000, e}, '0);
    end
    apb(1'b1, 16'h9000, '1);
    chk({31'h0000_0000, e}, 32'h0000_0001);
    src_event <= 32'h8000_0001;
    @(posedge pclk);
    src_event <= '0;
    hot_reset <= 1'b1;
    @(posedge pclk);
    hot_reset <= 1'b0;
    apb(1'b1, isl_pkg::ISL_OFF_IRQ_CLR, 32'h0000_0007);
    apb(1'b1, isl_pkg::ISL_OFF_IRQ_EN, 32'h0000_0001);
    src_event <= 32'h0000_0010;
    repeat (5) @(posedge pclk);
    src_event <= '0;
    chk({31'h0000_0000, irq}, 32'h0000_0001);
    apb(1'b1, isl_pkg::ISL_OFF_IRQ_EN, '0);
    repeat (3) @(posedge pclk);
    chk({31'h0000_0000, irq}, '0);
    apb(1'b1, isl_pkg::ISL_OFF_IRQ_CLR, 32'h0000_0007);
    apb(1'b1, isl_pkg::ISL_OFF_IRQ_EN, 32'h0000_0001);
    repeat (3) @(posedge pclk);
    chk({31'h0000_0000, irq}, '0);
    print_verdict;
  end
endmodule
`default_nettype wire
